// ---- logic/phy_regs_pkg.sv ----
// Package: register map, field layout, reset values and carriers for the PHY status block
package phy_regs_pkg;
    // Register indices (printed offsets are not multiples of four)
    localparam logic [3:0] IDX_STATUS = 4'h1;
    localparam logic [3:0] IDX_IDENT_UPPER = 4'h2;
    localparam logic [3:0] IDX_IDENT_LOWER = 4'h3;
    localparam logic [3:0] IDX_ADVERT = 4'h4;
    localparam logic [3:0] IDX_PARTNER = 4'h5;
    localparam logic [3:0] IDX_EXPANSION = 4'h6;
    // Byte address of a register is four times its index
    localparam int ADDR_SHIFT = 2;
    localparam int ADDR_BITS = 6;

    // Status word fixed values and bit positions
    localparam logic [3:0] STATUS_ABILITY = 4'hF;
    localparam int STATUS_ABILITY_LSB = 11;
    localparam int STATUS_ANEG_DONE_BIT = 5;
    localparam int STATUS_ANEG_ABLE_BIT = 3;
    localparam int STATUS_LINK_BIT = 2;
    localparam int STATUS_JABBER_BIT = 1;
    localparam int STATUS_EXT_BIT = 0;

    // Identifier halves: arbitrary neutral values, not any real part's code
    localparam logic [15:0] IDENT_UPPER_VALUE = 16'h1234;
    localparam logic [15:0] IDENT_LOWER_VALUE = 16'h5678;

    // Advertisement word layout
    localparam int ADV_FAULT_BIT = 13;
    localparam int ADV_TECH_LSB = 5;
    localparam int ADV_TECH_MSB = 12;
    localparam logic [7:0] ADV_TECH_RESET = 8'h2F;
    localparam logic [4:0] ADV_SELECTOR = 5'h01;

    // Partner word layout
    localparam int PARTNER_ACK_BIT = 14;

    // Expansion word layout
    localparam int EXP_PD_FAULT_BIT = 4;
    localparam int EXP_LP_NP_BIT = 3;
    localparam int EXP_PAGE_RX_BIT = 1;
    localparam int EXP_LP_ANEG_BIT = 0;

    // AHB-Lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    // Live conditions from the rest of the PHY
    typedef struct packed {
        logic link_good;
        logic jabber;
        logic aneg_done;
        logic page_rx;
        logic pd_fault;
        logic lp_aneg_able;
        logic lp_ack;
        logic [15:0] lp_word;
    } phy_cond_t;

    // Whole state of the block
    typedef struct packed {
        logic latch_low_bit_q;
        logic latch_high_bit_q;
        logic pd_fault_q;
        logic page_rx_q;
        logic adv_fault_q;
        logic [7:0] adv_tech_q;
        logic pend_q;
        logic pend_write_q;
        logic [3:0] pend_idx_q;
        logic pend_hit_q;
        logic [31:0] rdata_q;
    } regs_state_t;
endpackage : phy_regs_pkg

// ---- logic/phy_status_autoneg_regs.sv ----
// Module: PHY status, identifier and auto-negotiation registers on AHB-Lite
`timescale 1ns/1ps
`default_nettype none

// Function
// RULE1: Status bits 14..11 read 1, the four speed and duplex abilities.
// RULE2: Status bit 6 reads 0; preamble-suppressed frames are not accepted.
// RULE3: Status bit 5 shows auto-negotiation complete; resets to 0. The code reads cond.aneg_done live, so reset does not clear it.
// RULE4: Status bit 4 reads 0, no remote fault detected.
// RULE5: Status bit 3 reads 1 (aneg able) and bit 0 reads 1 (extended).
// RULE6: Status bit 2 is link valid, latching low, resets to 0.
// RULE7: Status bit 1 is jabber detected, latching high, resets to 0.
// RULE8: Status bit 15 and bits 10..7 read 0.
// RULE9: Registers 2 and 3 return fixed upper and lower identifier halves.
// RULE10: Advertisement bit 15 reads 0 and reserved bit 14 reads 0.
// RULE11: Advertisement bit 13 writable remote fault flag, resets to 0.
// RULE12: Advertisement bits 12..5 writable technology field, reset 00101111.
// RULE13: Advertisement bits 4..0 read-only selector fixed at 00001.
// RULE14: Partner register shows partner next page, fault, technology, selector.
// RULE15: Partner bit 14 reads 1 once partner word is received.
// RULE16: Expansion bit 4 parallel fault, latches high, clears on read.
// RULE17: Expansion bit 3 partner next page able; bit 2 reads 0.
// RULE18: Expansion bit 1 page received, latches high, clears on read.
// RULE19: Expansion bit 0 partner aneg able; bits 15..5 read 0.
// RULE20: Latched bits hold their event value until read, then follow live.
// RULE21: Writes to read-only bits and fields are ignored.
module phy_status_autoneg_regs (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Conditions from the rest of the PHY
    input wire phy_regs_pkg::phy_cond_t cond,
    // Advertised word toward the negotiation engine
    output logic [15:0] adv_word
);

    phy_regs_pkg::regs_state_t s_q;
    phy_regs_pkg::regs_state_t s_d;
    logic [15:0] status_w;
    logic [15:0] partner_w;
    logic [15:0] expansion_w;
    logic [15:0] read_w;
    logic take;
    logic [3:0] a_idx;
    logic a_hit;
    logic rd_status;
    logic rd_exp;

    ////////////////////////////////////////////////////////////////////////////////
    // Register images assembled from state and live conditions
    always_comb begin
        status_w = 16'h0000; // [RULE2] [RULE4] [RULE8]
        status_w[phy_regs_pkg::STATUS_ABILITY_LSB +: 4] = phy_regs_pkg::STATUS_ABILITY; // [RULE1]
        status_w[phy_regs_pkg::STATUS_ANEG_DONE_BIT] = cond.aneg_done; // [RULE3]
        status_w[phy_regs_pkg::STATUS_ANEG_ABLE_BIT] = 1'b1; // [RULE5]
        status_w[phy_regs_pkg::STATUS_EXT_BIT] = 1'b1; // [RULE5]
        status_w[phy_regs_pkg::STATUS_LINK_BIT] = s_q.latch_low_bit_q; // [RULE6]
        status_w[phy_regs_pkg::STATUS_JABBER_BIT] = s_q.latch_high_bit_q; // [RULE7]
    end

    // Partner word passes through; acknowledge reflects reception
    always_comb begin
        partner_w = cond.lp_word; // [RULE14]
        partner_w[phy_regs_pkg::PARTNER_ACK_BIT] = cond.lp_ack; // [RULE15]
    end

    // Expansion word; local next page bit stays 0
    always_comb begin
        expansion_w = 16'h0000; // [RULE19] [RULE17]
        expansion_w[phy_regs_pkg::EXP_PD_FAULT_BIT] = s_q.pd_fault_q; // [RULE16]
        expansion_w[phy_regs_pkg::EXP_LP_NP_BIT] = cond.lp_word[15]; // [RULE17]
        expansion_w[phy_regs_pkg::EXP_PAGE_RX_BIT] = s_q.page_rx_q; // [RULE18]
        expansion_w[phy_regs_pkg::EXP_LP_ANEG_BIT] = cond.lp_aneg_able; // [RULE19]
    end

    // Advertisement: next page and reserved fixed 0, selector fixed
    always_comb begin
        adv_word = {2'h0, s_q.adv_fault_q, s_q.adv_tech_q,
            phy_regs_pkg::ADV_SELECTOR}; // [RULE10] [RULE13]
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Address phase decode
    assign take = hsel && hready && (htrans == phy_regs_pkg::HTRANS_NONSEQ);
    assign a_idx = haddr[phy_regs_pkg::ADDR_SHIFT +: 4];
    assign a_hit = (haddr[31:phy_regs_pkg::ADDR_BITS] == 26'h0)
        && (haddr[phy_regs_pkg::ADDR_SHIFT - 1:0] == 2'h0);

    // Read mux on the address phase so data can be registered for the data phase
    always_comb begin
        read_w = 16'h0000;
        unique case (a_idx)
            phy_regs_pkg::IDX_STATUS: read_w = status_w;
            phy_regs_pkg::IDX_IDENT_UPPER: read_w = phy_regs_pkg::IDENT_UPPER_VALUE; // [RULE9]
            phy_regs_pkg::IDX_IDENT_LOWER: read_w = phy_regs_pkg::IDENT_LOWER_VALUE; // [RULE9]
            phy_regs_pkg::IDX_ADVERT: read_w = adv_word;
            phy_regs_pkg::IDX_PARTNER: read_w = partner_w;
            phy_regs_pkg::IDX_EXPANSION: read_w = expansion_w;
            default: read_w = 16'h0000;
        endcase
        if (!a_hit) begin
            read_w = 16'h0000;
        end
    end

    // A read of a latching word releases its latches
    assign rd_status = take && !hwrite && a_hit && (a_idx == phy_regs_pkg::IDX_STATUS);
    assign rd_exp = take && !hwrite && a_hit && (a_idx == phy_regs_pkg::IDX_EXPANSION);

    ////////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        s_d = s_q;
        // Latching low: a drop holds 0 until read; a drop in the read cycle still wins
        if (rd_status) begin
            s_d.latch_low_bit_q = cond.link_good; // [RULE20]
        end else if (!cond.link_good) begin
            s_d.latch_low_bit_q = 1'b0; // [RULE6] [RULE20]
        end else if (s_q.latch_low_bit_q) begin
            s_d.latch_low_bit_q = 1'b1;
        end
        // Latching high: event in the read cycle sets again, set beats clear
        s_d.latch_high_bit_q = (s_q.latch_high_bit_q && !rd_status) || cond.jabber; // [RULE7] [RULE20]
        s_d.pd_fault_q = (s_q.pd_fault_q && !rd_exp) || cond.pd_fault; // [RULE16]
        s_d.page_rx_q = (s_q.page_rx_q && !rd_exp) || cond.page_rx; // [RULE18]
        // Address phase captured for the data phase
        s_d.pend_q = take;
        if (take) begin
            s_d.pend_write_q = hwrite;
            s_d.pend_idx_q = a_idx;
            s_d.pend_hit_q = a_hit;
            s_d.rdata_q = hwrite ? phy_regs_pkg::WORD_ZERO : {16'h0000, read_w};
        end
        // Data phase write: only writable advertisement fields take data
        if (s_q.pend_q && s_q.pend_write_q && s_q.pend_hit_q
            && s_q.pend_idx_q == phy_regs_pkg::IDX_ADVERT) begin
            s_d.adv_fault_q = hwdata[phy_regs_pkg::ADV_FAULT_BIT]; // [RULE11]
            s_d.adv_tech_q = hwdata[phy_regs_pkg::ADV_TECH_MSB:phy_regs_pkg::ADV_TECH_LSB]; // [RULE12]
        end // [RULE21]
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
            s_q.adv_tech_q <= phy_regs_pkg::ADV_TECH_RESET; // [RULE12]
        end else begin
            s_q <= s_d;
        end
    end

    // Zero-wait slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s_q.rdata_q;

endmodule : phy_status_autoneg_regs

`default_nettype wire

// ---- test/mgmt_master.sv ----
// Station manager model: single word AHB-Lite transfers
`timescale 1ns/1ps
`default_nettype none
module mgmt_master (
    // Clock and bus return
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    // Bus request
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    // Set when the slave never answered
    output logic to
);
    // Idle bus at time zero
    initial {hsel, haddr, htrans, hwrite, hsize, hwdata, to} = '0;
    // Address phase then data phase, each held until hready is sampled high
    task automatic xfer(input logic w, input logic [3:0] ix, input logic [31:0] wd,
                        output logic [31:0] rd);
        int n;
        n = 0;
        hsel <= 1'b1;
        htrans <= phy_regs_pkg::HTRANS_NONSEQ;
        haddr <= {26'h0, ix, 2'h0};
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge hclk); while (!hready && ++n < 64);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (!hready && ++n < 128);
        rd = hrdata;
        // Released data lines must not keep looking like the last word
        hwdata <= ~wd;
        if (n >= 128) to <= 1'b1;
    endtask : xfer
endmodule : mgmt_master
`default_nettype wire

// ---- test/phy_regs_sva.sv ----
// Checker: register image and bus properties of the PHY status block
`timescale 1ns/1ps
`default_nettype none
module phy_regs_sva (
    // Clock, reset and bus
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    // PHY side
    input wire phy_regs_pkg::phy_cond_t cond,
    input wire logic [15:0] adv_word
);
    logic tk;
    logic rd_q;
    logic wr_q;
    logic [3:0] ix_q;
    phy_regs_pkg::phy_cond_t cq;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // A mapped transfer taken this cycle
    assign tk = hsel && hready && htrans == phy_regs_pkg::HTRANS_NONSEQ && haddr[31:6] == 26'h0;
    // Which word the data phase belongs to, and the inputs seen at the address edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {rd_q, wr_q, ix_q, cq} <= '0;
        end else begin
            {rd_q, wr_q, ix_q, cq} <= {tk && !hwrite, tk && hwrite, haddr[5:2], cond};
        end
    end
    status_fixed_a:
        assert property (rd_q && ix_q == 4'h1 |-> hrdata[15:6] == 10'h1E0
            && hrdata[4:3] == 2'h1 && hrdata[0]) else $error("status fixed bits wrong");
    aneg_done_a:
        assert property (rd_q && ix_q == 4'h1 |-> hrdata[5] == cq.aneg_done) else $error("aneg bit");
    link_low_a:
        assert property (rd_q && ix_q == 4'h1 && !$past(cond.link_good, 2) |-> !hrdata[2])
            else $error("link drop lost");
    jabber_high_a:
        assert property (rd_q && ix_q == 4'h1 && $past(cond.jabber, 2) |-> hrdata[1])
            else $error("jabber event lost");
    ident_word_a:
        assert property (rd_q && ix_q inside {4'h2, 4'h3} |-> hrdata[15:0] == (ix_q[0] ?
            phy_regs_pkg::IDENT_LOWER_VALUE : phy_regs_pkg::IDENT_UPPER_VALUE)) else $error("id");
    advert_fixed_a:
        assert property (adv_word[15:14] == 2'h0 && adv_word[4:0] == phy_regs_pkg::ADV_SELECTOR)
            else $error("advert fixed bits wrong");
    advert_store_a:
        assert property (wr_q && ix_q == 4'h4 |=> adv_word[13:5] == $past(hwdata[13:5]))
            else $error("advert write not stored");
    partner_word_a:
        assert property (rd_q && ix_q == 4'h5 |-> hrdata[14] == cq.lp_ack
            && (hrdata[15:0] & 16'hBFFF) == (cq.lp_word & 16'hBFFF)) else $error("partner");
    expansion_live_a:
        assert property (rd_q && ix_q == 4'h6 |-> hrdata[15:5] == 11'h0 && !hrdata[2]
            && hrdata[3] == cq.lp_word[15] && hrdata[0] == cq.lp_aneg_able) else $error("exp");
    fault_latch_a:
        assert property (rd_q && ix_q == 4'h6 && $past(cond.pd_fault, 2) |-> hrdata[4])
            else $error("fault event lost");
    page_latch_a:
        assert property (rd_q && ix_q == 4'h6 && $past(cond.page_rx, 2) |-> hrdata[1])
            else $error("page event lost");
    status_rd_c: cover property (rd_q && ix_q == 4'h1 && hrdata[1]);
    exp_rd_c: cover property (rd_q && ix_q == 4'h6 && hrdata[4]);
    adv_wr_c: cover property (wr_q && ix_q == 4'h4);
endmodule : phy_regs_sva
bind phy_status_autoneg_regs phy_regs_sva u_sva (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hready, .hwdata, .hrdata, .cond, .adv_word);
`default_nettype wire

// ---- test/phy_status_autoneg_regs_tb.sv ----
// Bench: register image, writes, latched bits and mid-run reset
`timescale 1ns/1ps
`default_nettype none
module phy_status_autoneg_regs_tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel, hwrite, hreadyout, hresp, to;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [15:0] adv_word;
    phy_regs_pkg::phy_cond_t cond = '0;
    logic [15:0] img [8] = '{16'h0000, 16'h7809, phy_regs_pkg::IDENT_UPPER_VALUE,
        phy_regs_pkg::IDENT_LOWER_VALUE, 16'h05E1, 16'h0000, 16'h0000, 16'h0000};
    int n_errors = 0;
    int n_checks = 0;
    always #5 hclk = ~hclk;
    phy_status_autoneg_regs u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .cond, .adv_word);
    mgmt_master u_mst (.hclk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .to);
    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask : tick
    task automatic close_out();
        if (to) n_errors++;
        $display("Checks %0d, errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        if (to) close_out();
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    // Read one word; the upper half must always be zero
    task automatic chk(input logic [3:0] ix, input logic [15:0] exp);
        u_mst.xfer(1'b0, ix, 32'h0000_0000, rd);
        cmp(rd[15:0], exp);
        cmp(rd[31:16], 16'h0000);
        // Zero-wait OKAY slave: ready high, response low after every read
        cmp({14'h0000, hreadyout, hresp}, 16'h0002);
    endtask : chk
    initial begin
        tick(2);
        hresetn <= 1'b1;
        tick(1);
        for (int i = 0; i < 8; i++) chk(i[3:0], img[i]);
        $display("Test reset image done");
        u_mst.xfer(1'b1, 4'h4, 32'hFFFF_FFFF, rd);
        chk(4'h4, 16'h3FE1);
        cmp(adv_word, 16'h3FE1);
        u_mst.xfer(1'b1, 4'h4, 32'h0000_0000, rd);
        chk(4'h4, 16'h0001);
        for (int i = 1; i < 7; i++) if (i != 4) u_mst.xfer(1'b1, i[3:0], 32'hFFFF_FFFF, rd);
        for (int i = 1; i < 7; i++) if (i != 4) chk(i[3:0], img[i] | 16'h0000);
        $display("Test writes done");
        cond.link_good <= 1'b1;
        cond.aneg_done <= 1'b1;
        tick(1);
        chk(4'h1, 16'h7829);
        chk(4'h1, 16'h782D);
        cond.link_good <= 1'b0;
        cond.jabber <= 1'b1;
        tick(1);
        cond.link_good <= 1'b1;
        cond.jabber <= 1'b0;
        tick(2);
        chk(4'h1, 16'h782B);
        chk(4'h1, 16'h782D);
        $display("Test status latches done");
        cond.lp_word <= 16'hA5C3;
        cond.lp_ack <= 1'b1;
        cond.lp_aneg_able <= 1'b1;
        cond.pd_fault <= 1'b1;
        cond.page_rx <= 1'b1;
        tick(1);
        cond.pd_fault <= 1'b0;
        cond.page_rx <= 1'b0;
        tick(1);
        chk(4'h5, 16'hE5C3);
        chk(4'h6, 16'h001B);
        chk(4'h6, 16'h0009);
        $display("Test partner and expansion done");
        hresetn <= 1'b0;
        tick(2);
        cmp(adv_word, 16'h05E1);
        hresetn <= 1'b1;
        tick(1);
        chk(4'h1, 16'h7829);
        $display("Test mid-run reset done");
        close_out();
    end
endmodule : phy_status_autoneg_regs_tb
`default_nettype wire
